/* scstwg_baud.sv */
/*
  modulus counter giving one pulse per serial clock half period.
  assumes divisor is held stable while run is high.
*/
`timescale 1ns/1ps
module scstwg_baud
  import scstwg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [7:0] divisor,
  output logic baud_edge
);
  typedef struct packed {
    logic [7:0] cnt;
    logic phase;
  } scstwg_baud_t;
  scstwg_baud_t b_reg;
  scstwg_baud_t b_next;
  logic [7:0] lo_half;
  logic [7:0] hi_half;
  logic [7:0] target;
  always_comb
  begin
    lo_half = divisor >> 1;
    if (lo_half == 8'h00)
      lo_half = 8'h01;
    hi_half = divisor - (divisor >> 1);
    target = b_reg.phase ? lo_half : hi_half;
    b_next = b_reg;
    if (!run)
    begin
      b_next.cnt = 8'h01;
      b_next.phase = 1'b0;
    end
    else if (b_reg.cnt >= target)
    begin
      b_next.cnt = 8'h01;
      b_next.phase = ~b_reg.phase;
    end
    else
      b_next.cnt = b_reg.cnt + 8'h01;
  end
  // full period equals divisor core clocks for divisor 2 and up, two core clocks for 0 or 1
  assign baud_edge = run && (b_reg.cnt >= target);
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      b_reg <= '{cnt: 8'h01, phase: 1'b0};
    else
      b_reg <= b_next;
  end
endmodule : scstwg_baud

/* scstwg_pkg.sv */
/*
  constants, field layout and state encoding for the chip select timing
  and register write guard block.
  assumes a single core clock and a simple word-wide peripheral bus.
*/
// Behaviour
// - inter-transfer gap is 32 times field value
// - gap follows every transfer whose gap field is nonzero, before any deselect
// - select-to-clock wait: half period, or setup field plus half period
// - serial clock divides core clock by divisor (2 and up), by 2 for divisor 0 or 1
// - length code maps to 8-16 or 4-7
// - hold bit keeps select until other select
// - hold clear drops select after last transfer
// - reload before end keeps select between transfers
// - force bit deselects between transfers, minimum gap
// - phase bit picks capture and change edges
// - idle serial clock equals polarity bit
// - guard enable changes only with key
// - guard enable bit turns protection on
// - violation records offending register offset; a software reset while guarded leaves it unchanged
// - status bit0 marks a blocked write
// - status bit1 marks software reset while guarded
// - status bit2 marks write during active select; only mode writes and writes to the selected config set it
// - status bits combine as bitwise or
package scstwg_pkg;
  localparam int NUM_CS = 4;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_IER = 8'h14;
  localparam logic [7:0] OFF_IDR = 8'h18;
  localparam logic [7:0] OFF_CSR0 = 8'h30;
  localparam logic [7:0] OFF_CHIP_SELECT3_CONFIG = 8'h3c;
  localparam logic [7:0] OFF_WGCTRL = 8'he4;
  localparam logic [7:0] OFF_WGSTAT = 8'he8;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam int CTRL_SWRST_BIT = 7;
  localparam int CFG_POL = 0;
  localparam int CFG_PHA = 1;
  localparam int CFG_FORCE = 2;
  localparam int CFG_HOLD = 3;
  localparam int CFG_BITS_LSB = 4;
  localparam int CFG_BAUD_LSB = 8;
  localparam int CFG_SETUP_LSB = 16;
  localparam int CFG_GAP_LSB = 24;
  localparam int MODE_BSEL_LSB = 24;
  localparam logic [23:0] GUARD_KEY = 24'h535049;
  localparam int KEY_LSB = 8;
  localparam int GEN_BIT = 0;
  localparam int STAT_SRC_LSB = 8;
  localparam int VS_BLOCKED = 0;
  localparam int VS_SWRST = 1;
  localparam int VS_BUSYWR = 2;
  localparam int GAP_MULT = 32;
  localparam logic [3:0] BITS_WIDE_MAX = 4'h8;
  localparam logic [3:0] BITS_NARROW_MAX = 4'hc;
  localparam logic [4:0] BITS_WIDE_BASE = 5'h08;
  localparam logic [4:0] BITS_NARROW_SUB = 5'h05;
  localparam int TIMER_W = 13;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SETUP = 6'h02,
    ST_SHIFT = 6'h04,
    ST_GAP = 6'h08,
    ST_DESEL = 6'h10,
    ST_HOLD = 6'h20
  } scstwg_state_t;
endpackage : scstwg_pkg

/* scstwg_slave_model.sv */
/*
  passive serial slave seen from the select and clock lines.
  assumes the serial clock is registered on core_clk.
*/
`timescale 1ns/1ps
module scstwg_slave_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic [3:0] sel_b,
  output logic frame_done,
  output logic [5:0] frame_edges,
  output logic [7:0] lead,
  output logic [7:0] max_quiet,
  output logic [7:0] half
);
  logic [3:0] sel_q;
  logic sclk_q;
  logic seen;
  logic [7:0] quiet;
  always_ff @(posedge core_clk)
  begin
    sel_q <= sel_b;
    sclk_q <= sclk;
    frame_done <= sel_q != 4'hf && sel_b != sel_q;
    if (!rst_b || frame_done)
    begin
      frame_edges <= 6'h00;
      seen <= 1'b0;
      lead <= 8'h00;
      quiet <= 8'h00;
      max_quiet <= 8'h00;
    end
    // frame spans from the first low select to one cycle after release
    else if ((sel_b & sel_q) != 4'hf)
    begin
      // count toggles, wait before first toggle and longest pause
      if (sclk != sclk_q)
      begin
        frame_edges <= frame_edges + 6'h01;
        seen <= 1'b1;
        quiet <= 8'h00;
        half <= quiet + 8'h01;
      end
      else if (!seen)
        lead <= lead + 8'h01;
      else
      begin
        quiet <= quiet + 8'h01;
        if (quiet >= max_quiet)
          max_quiet <= quiet + 8'h01;
      end
    end
    if (!rst_b)
      sel_q <= 4'hf;
  end
endmodule : scstwg_slave_model

/* scstwg_timer.sv */
/*
  down counter for setup, gap and deselect waits.
  assumes load is never given a zero value.
*/
`timescale 1ns/1ps
module scstwg_timer
  import scstwg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [scstwg_pkg::TIMER_W-1:0] value,
  output logic expire
);
  typedef struct packed {
    logic [TIMER_W-1:0] cnt;
  } scstwg_timer_t;
  scstwg_timer_t t_reg;
  scstwg_timer_t t_next;
  always_comb
  begin
    t_next = t_reg;
    if (load)
      t_next.cnt = value;
    else if (t_reg.cnt != '0)
      t_next.cnt = t_reg.cnt - 1'b1;
  end
  assign expire = !load && (t_reg.cnt == {{(TIMER_W-1){1'b0}}, 1'b1});
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      t_reg <= '0;
    else
      t_reg <= t_next;
  end
endmodule : scstwg_timer

/* scstwg_top.sv */
/*
  chip select timing sequencer with per-select configuration and the
  keyed register write guard with violation status.
  assumes requests come from logic on core_clk and obey xfer_ready.
*/
`timescale 1ns/1ps
module scstwg_top
  import scstwg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] pb_addr,
  input wire logic pb_write,
  input wire logic pb_read,
  input wire logic [31:0] pb_wdata,
  output logic [31:0] pb_rdata,
  input wire logic xfer_request,
  input wire logic [1:0] xfer_cs,
  output logic xfer_ready,
  output logic [4:0] xfer_bits,
  output logic change_strobe,
  output logic capture_strobe,
  output logic xfer_done,
  output logic serial_clock_out,
  output logic [scstwg_pkg::NUM_CS-1:0] peripheral_select_line_b,
  output logic [31:0] mode_word
);
  typedef struct packed {
    scstwg_state_t st;
    logic [NUM_CS-1:0][31:0] cfg;
    logic [31:0] mode;
    logic guard_en;
    logic [2:0] vs;
    logic [7:0] src;
    logic [31:0] rdata;
    logic [1:0] cur;
    logic cs_on;
    logic pend;
    logic [1:0] pend_cs;
    logic [5:0] edges;
    logic sclk;
    logic done;
  } scstwg_top_t;

  function automatic logic [4:0] bits_of(input logic [3:0] code);
    if (code <= BITS_WIDE_MAX)
      bits_of = BITS_WIDE_BASE + {1'b0, code};
    else if (code <= BITS_NARROW_MAX)
      bits_of = {1'b0, code} - BITS_NARROW_SUB;
    else
      bits_of = BITS_WIDE_BASE;
  endfunction : bits_of

  scstwg_top_t state_reg;
  scstwg_top_t state_next;
  logic [31:0] cur_cfg;
  logic [31:0] new_cfg;
  logic [7:0] gap_f;
  logic [7:0] setup_f;
  logic [7:0] bsel_f;
  logic [4:0] bits_now;
  logic [5:0] last_edge;
  logic wr_cfg;
  logic [1:0] wr_idx;
  logic wr_mode;
  logic blocked;
  logic busy_wr;
  logic swrst;
  logic clr_swrst;
  logic stat_read;
  logic req_v;
  logic [1:0] req_cs;
  logic finish;
  logic start;
  logic [1:0] start_cs;
  logic leading;
  logic timer_load;
  logic [TIMER_W-1:0] timer_val;
  logic timer_expire;
  logic baud_run;
  logic baud_edge;

  scstwg_timer u_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .load(timer_load),
    .value(timer_val),
    .expire(timer_expire)
  );

  scstwg_baud u_baud (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .run(baud_run),
    .divisor(cur_cfg[CFG_BAUD_LSB +: 8]),
    .baud_edge(baud_edge)
  );

  always_comb
  begin
    state_next = state_reg;
    state_next.done = 1'b0;
    cur_cfg = state_reg.cfg[state_reg.cur];
    gap_f = cur_cfg[CFG_GAP_LSB +: 8];
    setup_f = 8'h00;
    bsel_f = state_reg.mode[MODE_BSEL_LSB +: 8];
    bits_now = bits_of(cur_cfg[CFG_BITS_LSB +: 4]);
    last_edge = {bits_now, 1'b0} - 6'h01;
    baud_run = (state_reg.st == ST_SHIFT);
    leading = !state_reg.edges[0];
    timer_load = 1'b0;
    timer_val = '0;
    finish = 1'b0;
    start = 1'b0;
    start_cs = 2'h0;
    new_cfg = RESET_WORD;
    // bus decode
    wr_cfg = pb_write && (pb_addr >= OFF_CSR0) && (pb_addr <= OFF_CHIP_SELECT3_CONFIG) && (pb_addr[1:0] == 2'h0);
    wr_idx = pb_addr[3:2];
    wr_mode = pb_write && (pb_addr == OFF_MODE);
    blocked = (wr_cfg || wr_mode) && state_reg.guard_en;
    busy_wr = (wr_mode && state_reg.cs_on) || (wr_cfg && state_reg.cs_on && state_reg.cur == wr_idx);
    swrst = pb_write && (pb_addr == OFF_CTRL) && pb_wdata[CTRL_SWRST_BIT];
    clr_swrst = wr_mode || wr_cfg || (pb_write && (pb_addr == OFF_IER || pb_addr == OFF_IDR));
    stat_read = pb_read && (pb_addr == OFF_WGSTAT);
    // violation status, set wins over clear
    if (stat_read)
      state_next.vs = 3'h0;
    if (clr_swrst)
      state_next.vs[VS_SWRST] = 1'b0;
    if (blocked)
      state_next.vs[VS_BLOCKED] = 1'b1;
    if (swrst && state_reg.guard_en)
      state_next.vs[VS_SWRST] = 1'b1;
    if (busy_wr)
      state_next.vs[VS_BUSYWR] = 1'b1;
    if (blocked || busy_wr)
      state_next.src = pb_addr;
    if (pb_write && pb_addr == OFF_WGCTRL && pb_wdata[31:KEY_LSB] == GUARD_KEY)
      state_next.guard_en = pb_wdata[GEN_BIT];
    if (wr_mode && !blocked)
      state_next.mode = pb_wdata;
    if (wr_cfg && !blocked)
      state_next.cfg[wr_idx] = pb_wdata;
    // read data
    if (pb_read)
    begin
      case (pb_addr)
        OFF_MODE: state_next.rdata = state_reg.mode;
        OFF_WGCTRL: state_next.rdata = {31'h00000000, state_reg.guard_en};
        OFF_WGSTAT: state_next.rdata = {16'h0000, state_reg.src, 5'h00, state_reg.vs};
        default:
        begin
          if ((pb_addr >= OFF_CSR0) && (pb_addr <= OFF_CHIP_SELECT3_CONFIG) && (pb_addr[1:0] == 2'h0))
            state_next.rdata = state_reg.cfg[wr_idx];
          else
            state_next.rdata = 32'h00000000;
        end
      endcase
    end
    // requests
    req_v = state_reg.pend || xfer_request;
    req_cs = state_reg.pend ? state_reg.pend_cs : xfer_cs;
    if (xfer_request && !state_reg.pend && !(state_reg.st == ST_IDLE || state_reg.st == ST_HOLD))
    begin
      state_next.pend = 1'b1;
      state_next.pend_cs = xfer_cs;
    end
    // sequencer
    case (state_reg.st)
      ST_IDLE:
      begin
        if (req_v)
        begin
          start = 1'b1;
          start_cs = req_cs;
          state_next.pend = 1'b0;
        end
      end
      ST_SETUP:
      begin
        if (timer_expire)
          state_next.st = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        if (baud_edge)
        begin
          state_next.sclk = ~state_reg.sclk;
          state_next.edges = state_reg.edges + 6'h01;
          if (state_reg.edges == last_edge)
          begin
            state_next.done = 1'b1;
            state_next.edges = 6'h00;
            if (gap_f != 8'h00)
            begin
              timer_load = 1'b1;
              timer_val = TIMER_W'(GAP_MULT * gap_f);
              state_next.st = ST_GAP;
            end
            else
              finish = 1'b1;
          end
        end
      end
      ST_GAP:
      begin
        if (timer_expire)
          finish = 1'b1;
      end
      ST_HOLD:
      begin
        if (req_v)
        begin
          state_next.pend = 1'b0;
          if (req_cs == state_reg.cur)
          begin
            state_next.st = ST_SHIFT;
            state_next.edges = 6'h00;
          end
          else
          begin
            state_next.pend = 1'b1;
            state_next.pend_cs = req_cs;
            state_next.cs_on = 1'b0;
            timer_load = 1'b1;
            timer_val = (bsel_f == 8'h00) ? TIMER_W'(1) : TIMER_W'(bsel_f);
            state_next.st = ST_DESEL;
          end
        end
      end
      ST_DESEL:
      begin
        if (timer_expire)
        begin
          if (state_reg.pend)
          begin
            start = 1'b1;
            start_cs = state_reg.pend_cs;
            state_next.pend = 1'b0;
          end
          else
            state_next.st = ST_IDLE;
        end
      end
      default:
        state_next.st = ST_IDLE;
    endcase
    // end of transfer and gap
    if (finish)
    begin
      if (state_reg.pend && state_reg.pend_cs == state_reg.cur && (cur_cfg[CFG_HOLD] || !cur_cfg[CFG_FORCE]))
      begin
        state_next.pend = 1'b0;
        state_next.st = ST_SHIFT;
      end
      else if (state_reg.pend)
      begin
        state_next.cs_on = 1'b0;
        timer_load = 1'b1;
        timer_val = TIMER_W'(bsel_f) + ((gap_f == 8'h00) ? TIMER_W'(1) : TIMER_W'(0));
        if (timer_val == '0)
          timer_val = TIMER_W'(1);
        state_next.st = ST_DESEL;
      end
      else if (cur_cfg[CFG_HOLD])
        state_next.st = ST_HOLD;
      else
      begin
        state_next.cs_on = 1'b0;
        state_next.st = ST_IDLE;
      end
    end
    if (start)
    begin
      new_cfg = state_reg.cfg[start_cs];
      setup_f = new_cfg[CFG_SETUP_LSB +: 8];
      state_next.cur = start_cs;
      state_next.cs_on = 1'b1;
      state_next.edges = 6'h00;
      state_next.sclk = new_cfg[CFG_POL];
      // zero setup: baud counter supplies the half period
      if (setup_f == 8'h00)
        state_next.st = ST_SHIFT;
      else
      begin
        timer_load = 1'b1;
        timer_val = TIMER_W'(setup_f);
        state_next.st = ST_SETUP;
      end
    end
    if (state_reg.st != ST_SHIFT && !start)
      state_next.sclk = cur_cfg[CFG_POL];
    if (swrst)
    begin
      state_next.st = ST_IDLE;
      state_next.cfg = '0;
      state_next.mode = RESET_WORD;
      state_next.cs_on = 1'b0;
      state_next.pend = 1'b0;
      state_next.edges = 6'h00;
      state_next.sclk = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
      state_reg.st <= ST_IDLE;
    end
    else
      state_reg <= state_next;
  end

  assign pb_rdata = state_reg.rdata;
  assign xfer_ready = !state_reg.pend;
  assign xfer_bits = bits_now;
  assign capture_strobe = baud_edge && (leading == cur_cfg[CFG_PHA]);
  assign change_strobe = baud_edge && (leading != cur_cfg[CFG_PHA]);
  assign xfer_done = state_reg.done;
  assign serial_clock_out = state_reg.sclk;
  assign mode_word = state_reg.mode;
  assign peripheral_select_line_b = ~({{(NUM_CS-1){1'b0}}, state_reg.cs_on} << state_reg.cur);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  a_key_reject: assert property (pb_write && pb_addr == OFF_WGCTRL && pb_wdata[31:KEY_LSB] != GUARD_KEY
    |=> $stable(state_reg.guard_en)) else $error("guard enable moved without key");
  a_key_accept: assert property (pb_write && pb_addr == OFF_WGCTRL && pb_wdata[31:KEY_LSB] == GUARD_KEY
    |=> state_reg.guard_en == $past(pb_wdata[GEN_BIT])) else $error("keyed write ignored");
  a_blocked_keep: assert property (state_reg.guard_en && wr_cfg && !swrst
    |=> $stable(state_reg.cfg)) else $error("guarded config changed");
  a_open_write: assert property (!state_reg.guard_en && wr_mode && !swrst
    |=> state_reg.mode == $past(pb_wdata)) else $error("unguarded mode write lost");
  a_blocked_flag: assert property (state_reg.guard_en && (wr_cfg || wr_mode)
    |=> state_reg.vs[VS_BLOCKED] && state_reg.src == $past(pb_addr))
    else $error("blocked write not recorded");
  a_swrst_flag: assert property (swrst && state_reg.guard_en
    |=> state_reg.vs[VS_SWRST]) else $error("guarded reset not flagged");
  a_busy_flag: assert property (wr_mode && state_reg.cs_on
    |=> state_reg.vs[VS_BUSYWR]) else $error("write under select not flagged");
  a_read_clear: assert property (stat_read && !pb_write
    |=> state_reg.vs == 3'h0) else $error("status not cleared by read");
  a_gap_hold: assert property (xfer_done && gap_f != 8'h00 && !swrst
    |-> (state_reg.st == ST_GAP && state_reg.cs_on)[*8]) else $error("gap too short");
  a_drop_select: assert property (state_reg.done && state_reg.st == ST_IDLE
    |-> peripheral_select_line_b == {NUM_CS{1'b1}}) else $error("select left asserted");
  a_idle_level: assert property (state_reg.st == ST_IDLE && $past(state_reg.st) == ST_IDLE
    && $stable(cur_cfg) |-> serial_clock_out == cur_cfg[CFG_POL])
    else $error("idle clock level wrong");

  c_transfer: cover property (state_reg.st == ST_SHIFT ##[1:600] xfer_done);
  c_blocked: cover property (state_reg.guard_en && wr_cfg);
  c_hold: cover property (state_reg.st == ST_HOLD ##[1:100] state_reg.st == ST_DESEL);
  c_back_to_back: cover property (xfer_done && state_reg.pend);
endmodule : scstwg_top

/* tb_scstwg_top.sv */
/*
  self-checking bench for the select timing and write guard block.
  assumes the slave model on the select and serial clock lines.
*/
`timescale 1ns/1ps
module tb_scstwg_top;
  import scstwg_pkg::*;
  logic core_clk = 0, rst_b = 0, pb_write = 0, pb_read = 0, xfer_request = 0;
  logic [7:0] pb_addr = 8'h00;
  logic [31:0] pb_wdata = 32'h0, pb_rdata, mode_word;
  logic [1:0] xfer_cs = 2'h0;
  logic xfer_ready, change_strobe, capture_strobe, xfer_done, serial_clock_out;
  logic [4:0] xfer_bits;
  logic [NUM_CS-1:0] peripheral_select_line_b;
  logic frame_done, rd_pend = 0;
  logic [5:0] frame_edges;
  logic [7:0] lead, max_quiet, half;
  logic [31:0] rd_q[$], rm_q[$];
  logic [5:0] fr_q[$];
  int n_mismatch = 0, samples_checked = 0, seed = 31551, cyc = 0, c, nb;
  always #5 core_clk = ~core_clk;
  scstwg_top scstwg_top_inst (.core_clk, .rst_b, .pb_addr, .pb_write, .pb_read,
    .pb_wdata, .pb_rdata, .xfer_request, .xfer_cs, .xfer_ready, .xfer_bits,
    .change_strobe, .capture_strobe, .xfer_done, .serial_clock_out,
    .peripheral_select_line_b, .mode_word);
  scstwg_slave_model scstwg_slave_model_inst (.core_clk, .rst_b,
    .sclk(serial_clock_out), .sel_b(peripheral_select_line_b), .frame_done,
    .frame_edges, .lead, .max_quiet, .half);
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // results checked against the oldest note
  always @(posedge core_clk)
  begin
    rd_pend <= pb_read;
    cyc <= cyc + 1;
    if (rd_pend)
      cmp("pb_rdata", rd_q.pop_front(), pb_rdata & rm_q.pop_front());
    if (frame_done)
      cmp("frame_edges", 32'(fr_q.pop_front()), 32'(frame_edges));
    if (cyc == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge core_clk);
    pb_addr = a;
    pb_wdata = d;
    pb_write = 1;
    @(negedge core_clk);
    pb_write = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(negedge core_clk);
    pb_addr = a;
    pb_read = 1;
    rd_q.push_back(e & m);
    rm_q.push_back(m);
    @(negedge core_clk);
    pb_read = 0;
  endtask : rd
  task automatic go(input logic [1:0] cs, input int ne, input logic pha, input bit push);
    int k;
    k = 0;
    @(negedge core_clk);
    while (xfer_ready !== 1'b1 && k++ < 2000)
      @(negedge core_clk);
    xfer_request = 1;
    xfer_cs = cs;
    if (push)
      fr_q.push_back(6'(ne));
    @(negedge core_clk);
    xfer_request = 0;
    k = 0;
    // a queued request starts only once ready returns
    while (push && k++ < 2000 && (xfer_ready !== 1'b1
      || (change_strobe !== 1'b1 && capture_strobe !== 1'b1)))
      @(negedge core_clk);
    if (push)
    begin
      cmp("strobe_seen", 1, 32'(change_strobe | capture_strobe));
      cmp("capture_first", 32'(pha), 32'(capture_strobe));
    end
    else
      cmp("queued", 0, 32'(xfer_ready));
  endtask : go
  task automatic fin();
    int k;
    k = 0;
    @(negedge core_clk);
    while (xfer_done !== 1'b1 && k++ < 2000)
      @(negedge core_clk);
    cmp("xfer_done", 1, 32'(xfer_done));
  endtask : fin
  initial
  begin
    repeat (8) @(negedge core_clk);
    rst_b = 1;
    rd(OFF_WGCTRL, 0, '1);
    rd(OFF_WGSTAT, 0, '1);
    rd(OFF_CHIP_SELECT3_CONFIG, 0, '1);
    rd(8'h80, 0, '1);
    cmp("select", 4'hf, peripheral_select_line_b);
    wr(OFF_WGCTRL, 32'h12345601);
    rd(OFF_WGCTRL, 0, '1);
    wr(OFF_WGCTRL, {GUARD_KEY, 8'h01});
    rd(OFF_WGCTRL, 1, '1);
    wr(OFF_CHIP_SELECT3_CONFIG, $random(seed));
    rd(OFF_CHIP_SELECT3_CONFIG, 0, '1);
    wr(OFF_CTRL, 32'h80);
    rd(OFF_WGSTAT, 32'h3c03, 32'hff07);
    rd(OFF_WGSTAT, 0, 7);
    wr(OFF_WGSTAT, '1);
    rd(OFF_WGSTAT, 0, 7);
    wr(OFF_MODE, $random(seed));
    cmp("mode_word", 0, mode_word);
    rd(OFF_WGSTAT, 32'h0401, 32'hff07);
    wr(OFF_WGCTRL, {GUARD_KEY, 8'h00});
    rd(OFF_WGCTRL, 0, '1);
    for (int i = 0; i < 13; i++)
    begin
      wr(OFF_CSR0, {16'h0, 8'h04, 4'(i), 4'h0});
      cmp("xfer_bits", i <= 8 ? 8 + i : (i <= 12 ? i - 5 : 8), 32'(xfer_bits));
    end
    c = $unsigned($random(seed)) % 12;
    if (c > 7)
      c++;
    nb = c <= 8 ? 8 + c : c - 5;
    wr(OFF_CSR0, {16'h0, 8'h04, 4'(c), 4'h0});
    go(0, 2 * nb, 0, 1);
    fin();
    cmp("select", 4'hf, peripheral_select_line_b);
    cmp("sclk", 0, serial_clock_out);
    cmp("half", 2, half);
    cmp("lead", 1, lead >= 2);
    wr(OFF_CSR0, {8'h00, 8'd20, 8'h04, 4'(c), 4'h3});
    @(negedge core_clk);
    cmp("sclk", 1, serial_clock_out);
    go(0, 2 * nb, 1, 1);
    fin();
    cmp("lead", 1, lead >= 20);
    go(0, 2 * nb, 1, 1);
    wr(OFF_MODE, 32'h00000011);
    wr(OFF_CSR0, {8'h00, 8'd20, 8'h04, 4'(c), 4'h3});
    fin();
    cmp("mode_word", 32'h11, mode_word);
    rd(OFF_WGSTAT, 32'h3004, 32'hff07);
    wr(OFF_CSR0, {8'h01, 8'h00, 8'h04, 4'(c), 4'h0});
    go(0, 4 * nb, 0, 1);
    go(0, 0, 0, 0);
    fin();
    fin();
    cmp("quiet", 1, max_quiet >= 32);
    cmp("select", 4'he, peripheral_select_line_b);
    repeat (40) @(negedge core_clk);
    cmp("select", 4'hf, peripheral_select_line_b);
    wr(OFF_CSR0, {16'h0, 8'h04, 4'(c), 4'h4});
    go(0, 2 * nb, 0, 1);
    go(0, 2 * nb, 0, 1);
    fin();
    wr(8'h34, {16'h0, 8'h04, 4'(c), 4'h8});
    wr(8'h38, {16'h0, 8'h06, 4'(c), 4'h0});
    go(1, 2 * nb, 0, 1);
    fin();
    repeat (10) @(negedge core_clk);
    cmp("select", 4'hd, peripheral_select_line_b);
    go(2, 2 * nb, 0, 1);
    fin();
    cmp("half", 3, half);
    cmp("select", 4'hf, peripheral_select_line_b);
    repeat (4) @(negedge core_clk);
    cmp("frames_left", 0, fr_q.size());
    give_verdict();
  end
endmodule : tb_scstwg_top
